// *** design/flc_pkg.sv ***
// package for the flash lock-bit controller: register map, fields, timing
// assumes a 100 MHz ref_clk and an 8-bit asynchronous flash data bus
package flc_pkg;
   // clock rate and pin timing
   localparam int CLK_MHZ      = 100;
   localparam int T_WE_NS      = 100;   // write strobe width, least
   localparam int T_SETUP_NS   = 20;    // address/data setup, least
   localparam int T_ACC_NS     = 150;   // read access, least

   // least times round up to whole cycles, never below one
   function automatic int cyc_up(input int ns);
      int c;
      c = (ns * CLK_MHZ + 999) / 1000;
      return (c < 1) ? 1 : c;
   endfunction

   localparam int WE_CYC    = cyc_up(T_WE_NS);
   localparam int SETUP_CYC = cyc_up(T_SETUP_NS);
   localparam int ACC_CYC   = cyc_up(T_ACC_NS);
   localparam int CNT_W     = 8;

   // register byte addresses
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_ADDR   = 8'h04;
   localparam logic [7:0] OFS_CMD    = 8'h08;
   localparam logic [7:0] OFS_STAT   = 8'h0C;
   localparam logic [7:0] OFS_IRQ    = 8'h10;
   localparam logic [7:0] OFS_MASK   = 8'h14;
   localparam logic [7:0] OFS_RDATA  = 8'h18;

   // control register fields
   localparam int CTRL_WRITE   = 0;   // single command write, pulse
   localparam int CTRL_READ    = 1;   // single read, pulse
   localparam int CTRL_SEQ     = 2;   // setup+confirm then poll, pulse
   localparam int CTRL_OVR     = 3;   // override voltage request, level
   localparam int CTRL_PDN     = 4;   // hold protect pin low, level

   // device status byte layout
   localparam int SB_READY     = 7;   // machine_ready_bit
   localparam int SB_ERASE_ERR = 5;   // erase_clear_error_bit
   localparam int SB_PROG_ERR  = 4;   // program_setlock_error_bit
   localparam int SB_SUPPLY    = 3;   // supply_low_bit
   localparam int SB_PROTECT   = 1;   // device_protect_bit

   // event bits in irq status and mask
   localparam int EV_DONE      = 0;
   localparam int EV_ERASE_ERR = 1;
   localparam int EV_PROG_ERR  = 2;
   localparam int EV_SUPPLY    = 3;
   localparam int EV_PROTECT   = 4;
   localparam int EV_ABORT     = 5;
   localparam int EV_W         = 6;

   // reset values
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [15:0] CMD_RST  = 16'h0000;
   localparam logic [EV_W-1:0] MASK_RST = 6'h00;

   typedef enum logic {FLC_OP_WR, FLC_OP_RD} flc_op_t;
endpackage

// *** design/flc_bus_cycle.sv ***
// one asynchronous flash bus cycle (write or read) on the device pins
// assumes dq input comes from the pad; it is synchronised here
module flc_bus_cycle
   import flc_pkg::*;
#(
   parameter int ADDR_W = 20
) (
   input  wire logic              ref_clk,
   input  wire logic              rst,
   input  wire logic              start,
   input  wire flc_pkg::flc_op_t  op,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [7:0]        wdata,
   output logic                   done,
   output logic [7:0]             rdata,
   output logic [ADDR_W-1:0]      flash_addr,
   output logic                   flash_ce_n,
   output logic                   flash_oe_n,
   output logic                   flash_we_n,
   output logic [7:0]             flash_dq_o,
   output logic                   flash_dq_oe,
   input  wire logic [7:0]        flash_dq_i
);
   typedef enum {CY_IDLE, CY_SETUP, CY_STROBE, CY_HOLD} flc_cy_t;
   flc_cy_t          st_reg;
   flc_op_t          op_reg;
   logic [CNT_W-1:0] cnt_reg;
   logic [7:0]       dq_s1_reg;
   logic [7:0]       dq_s2_reg;

   // two-stage synchroniser on the data pins
   always_ff @(posedge ref_clk) begin
      dq_s1_reg <= flash_dq_i;
      dq_s2_reg <= dq_s1_reg;
   end

   // cycle sequencer; read waits access time plus sync delay
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st_reg      <= CY_IDLE;
         op_reg      <= FLC_OP_WR;
         cnt_reg     <= '0;
         done        <= 1'b0;
         rdata       <= 8'h00;
         flash_addr  <= '0;
         flash_ce_n  <= 1'b1;
         flash_oe_n  <= 1'b1;
         flash_we_n  <= 1'b1;
         flash_dq_o  <= 8'h00;
         flash_dq_oe <= 1'b0;
      end else begin
         done <= 1'b0;
         case (st_reg)
            CY_IDLE: begin
               if (start) begin
                  op_reg      <= op;
                  flash_addr  <= addr;
                  flash_dq_o  <= wdata;
                  flash_dq_oe <= (op == FLC_OP_WR);
                  flash_ce_n  <= 1'b0;
                  cnt_reg     <= CNT_W'(SETUP_CYC - 1);
                  st_reg      <= CY_SETUP;
               end
            end
            CY_SETUP: begin
               if (cnt_reg == '0) begin
                  if (op_reg == FLC_OP_WR) begin
                     flash_we_n <= 1'b0;
                     cnt_reg    <= CNT_W'(WE_CYC - 1);
                  end else begin
                     flash_oe_n <= 1'b0;
                     cnt_reg    <= CNT_W'(ACC_CYC + 1);
                  end
                  st_reg <= CY_STROBE;
               end else begin
                  cnt_reg <= cnt_reg - 1'b1;
               end
            end
            CY_STROBE: begin
               if (cnt_reg == '0) begin
                  flash_we_n <= 1'b1;   // data latched on rising strobe
                  flash_oe_n <= 1'b1;
                  if (op_reg == FLC_OP_RD) begin
                     rdata <= dq_s2_reg;
                  end
                  st_reg <= CY_HOLD;
               end else begin
                  cnt_reg <= cnt_reg - 1'b1;
               end
            end
            default: begin
               flash_ce_n  <= 1'b1;
               flash_dq_oe <= 1'b0;
               done        <= 1'b1;
               st_reg      <= CY_IDLE;
            end
         endcase
      end
   end
endmodule

// *** design/flc_ctrl.sv ***
// host controller for a flash clear-lock / status sequence, APB slave
// assumes the flash pins connect straight through; ready pin is async
//
// Function
// - Master lock set: host holds override voltage during clear-lock.
// - Two writes, setup then confirm; afterwards reads return status.
// - Host detects completion by ready pin or status bit seven; the sequencer waits for both.
// - Host checks erase/clear error bit; clears status on error.
// - Aborted clear leaves lock bits undefined; host must repeat it.
module flc_ctrl
   import flc_pkg::*;
#(
   parameter int ADDR_W = 20
) (
   input  wire logic              ref_clk,
   input  wire logic              rst,
   input  wire logic [7:0]        paddr,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   output logic                   irq,
   output logic [ADDR_W-1:0]      flash_addr,
   output logic                   flash_ce_n,
   output logic                   flash_oe_n,
   output logic                   flash_we_n,
   output logic [7:0]             flash_dq_o,
   output logic                   flash_dq_oe,
   input  wire logic [7:0]        flash_dq_i,
   output logic                   powerdown_protect_pin_n,
   output logic                   override_high_voltage,
   input  wire logic              ready_busy_pin
);
   import flc_pkg::*;

   // refuse address widths that the 32-bit register cannot hold
   if (ADDR_W < 1 || ADDR_W > 32) begin : g_bad_addr_w
      $error("flc_ctrl: ADDR_W must be 1..32");
   end

   typedef enum {S_IDLE, S_ONE, S_SETUP, S_CONFIRM, S_POLL} flc_st_t;
   flc_st_t             st_reg;
   logic [ADDR_W-1:0]   addr_reg;
   logic [15:0]         cmd_reg;
   logic [7:0]          status_reg;
   logic [7:0]          rdata_reg;
   logic [EV_W-1:0]     ev_reg;
   logic [EV_W-1:0]     mask_reg;
   logic                ovr_reg;
   logic                pdn_reg;
   logic                rb_s1_reg;
   logic                rb_s2_reg;
   logic                cy_start;
   flc_op_t             cy_op;
   logic [7:0]          cy_wdata;
   logic                cy_done;
   logic [7:0]          cy_rdata;
   logic                cy_busy_reg;
   logic                wr_acc;
   logic                ctrl_wr;
   logic [EV_W-1:0]     ev_set;

   // decode a register offset into a hit flag
   function automatic logic is_mapped(input logic [7:0] a);
      return (a == OFS_CTRL) || (a == OFS_ADDR) || (a == OFS_CMD) ||
             (a == OFS_STAT) || (a == OFS_IRQ)  || (a == OFS_MASK) ||
             (a == OFS_RDATA);
   endfunction

   assign wr_acc  = psel && penable && pwrite;
   assign ctrl_wr = wr_acc && (paddr == OFS_CTRL);

   // ready pin synchroniser
   always_ff @(posedge ref_clk) begin
      rb_s1_reg <= ready_busy_pin;
      rb_s2_reg <= rb_s1_reg;
   end

   flc_bus_cycle #(
      .ADDR_W      (ADDR_W)
   ) u_cycle (
      .ref_clk     (ref_clk),
      .rst         (rst),
      .start       (cy_start),
      .op          (cy_op),
      .addr        (addr_reg),
      .wdata       (cy_wdata),
      .done        (cy_done),
      .rdata       (cy_rdata),
      .flash_addr  (flash_addr),
      .flash_ce_n  (flash_ce_n),
      .flash_oe_n  (flash_oe_n),
      .flash_we_n  (flash_we_n),
      .flash_dq_o  (flash_dq_o),
      .flash_dq_oe (flash_dq_oe),
      .flash_dq_i  (flash_dq_i)
   );

   // APB slave: zero wait, read data prepared in the setup cycle
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pready  <= 1'b1;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready <= 1'b1;
         if (psel && !penable) begin
            pslverr <= !is_mapped(paddr);
            if (paddr == OFS_CTRL) begin
               prdata <= {27'h0, pdn_reg, ovr_reg, 3'h0};
            end else if (paddr == OFS_ADDR) begin
               prdata <= 32'(addr_reg);
            end else if (paddr == OFS_CMD) begin
               prdata <= {16'h0000, cmd_reg};
            end else if (paddr == OFS_STAT) begin
               prdata <= {21'h0, ovr_reg, rb_s2_reg,
                          (st_reg != S_IDLE) || cy_busy_reg, status_reg};
            end else if (paddr == OFS_IRQ) begin
               prdata <= {26'h0, ev_reg};
            end else if (paddr == OFS_MASK) begin
               prdata <= {26'h0, mask_reg};
            end else if (paddr == OFS_RDATA) begin
               prdata <= {24'h0, rdata_reg};
            end else begin
               prdata <= 32'h0000_0000;
            end
         end
      end
   end

   // software-held registers
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         addr_reg <= '0;
         cmd_reg  <= CMD_RST;
         mask_reg <= MASK_RST;
         ovr_reg  <= CTRL_RST[CTRL_OVR];
         pdn_reg  <= CTRL_RST[CTRL_PDN];
      end else if (wr_acc) begin
         if (paddr == OFS_ADDR) begin
            addr_reg <= pwdata[ADDR_W-1:0];
         end else if (paddr == OFS_CMD) begin
            cmd_reg <= pwdata[15:0];
         end else if (paddr == OFS_MASK) begin
            mask_reg <= pwdata[EV_W-1:0];
         end else if (paddr == OFS_CTRL) begin
            ovr_reg <= pwdata[CTRL_OVR];
            pdn_reg <= pwdata[CTRL_PDN];
         end
      end
   end

   // protect pin drive: low for powerdown, override raised on request only while not in powerdown
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         powerdown_protect_pin_n <= 1'b1;
         override_high_voltage   <= 1'b0;
      end else begin
         powerdown_protect_pin_n <= !pdn_reg;
         override_high_voltage   <= ovr_reg && !pdn_reg;
      end
   end

   // command sequencer: single cycles or setup, confirm, status poll
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st_reg     <= S_IDLE;
         cy_start   <= 1'b0;
         cy_op      <= FLC_OP_WR;
         cy_wdata   <= 8'h00;
         status_reg <= 8'h00;
         rdata_reg  <= 8'h00;
         ev_set     <= '0;
      end else begin
         cy_start <= 1'b0;
         ev_set   <= '0;
         case (st_reg)
            S_IDLE: begin
               if (ctrl_wr && !pwdata[CTRL_PDN] && !cy_busy_reg &&
                   !cy_start) begin
                  if (pwdata[CTRL_SEQ]) begin
                     cy_op    <= FLC_OP_WR;
                     cy_wdata <= cmd_reg[7:0];
                     cy_start <= 1'b1;
                     st_reg   <= S_SETUP;
                  end else if (pwdata[CTRL_WRITE]) begin
                     cy_op    <= FLC_OP_WR;
                     cy_wdata <= cmd_reg[7:0];
                     cy_start <= 1'b1;
                     st_reg   <= S_ONE;
                  end else if (pwdata[CTRL_READ]) begin
                     cy_op    <= FLC_OP_RD;
                     cy_start <= 1'b1;
                     st_reg   <= S_ONE;
                  end
               end
            end
            S_ONE: begin
               if (cy_done) begin
                  rdata_reg <= cy_rdata;
                  ev_set[EV_DONE] <= 1'b1;
                  st_reg <= S_IDLE;
               end
            end
            S_SETUP: begin
               if (cy_done) begin
                  cy_wdata <= cmd_reg[15:8];
                  cy_start <= 1'b1;
                  st_reg   <= S_CONFIRM;
               end
            end
            S_CONFIRM: begin
               if (cy_done) begin
                  cy_op    <= FLC_OP_RD;
                  cy_start <= 1'b1;
                  st_reg   <= S_POLL;
               end
            end
            default: begin
               if (cy_done) begin
                  status_reg <= cy_rdata;
                  if (cy_rdata[SB_READY] && rb_s2_reg) begin
                     ev_set[EV_DONE]      <= 1'b1;
                     ev_set[EV_ERASE_ERR] <= cy_rdata[SB_ERASE_ERR];
                     ev_set[EV_PROG_ERR]  <= cy_rdata[SB_PROG_ERR];
                     ev_set[EV_SUPPLY]    <= cy_rdata[SB_SUPPLY];
                     ev_set[EV_PROTECT]   <= cy_rdata[SB_PROTECT];
                     st_reg <= S_IDLE;
                  end else begin
                     cy_start <= 1'b1;
                  end
               end
            end
         endcase
         // powerdown mid-operation aborts; lock state then undefined
         if (pdn_reg && st_reg != S_IDLE) begin
            ev_set[EV_ABORT] <= 1'b1;
            st_reg <= S_IDLE;
         end
      end
   end

   // bus cycle in flight; an abort can leave one running to its end
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cy_busy_reg <= 1'b0;
      end else if (cy_start) begin
         cy_busy_reg <= 1'b1;
      end else if (cy_done) begin
         cy_busy_reg <= 1'b0;
      end
   end

   // sticky events, write one to clear; a new event beats the clear
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ev_reg <= '0;
      end else if (wr_acc && paddr == OFS_IRQ) begin
         ev_reg <= (ev_reg & ~pwdata[EV_W-1:0]) | ev_set;
      end else begin
         ev_reg <= ev_reg | ev_set;
      end
   end

   // level interrupt from unmasked events
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(ev_reg & mask_reg);
      end
   end
endmodule

// *** tb/flc_flash_model.sv ***
// flash device model: clear-lock command, status byte, ready pin
// assumes byte writes latch at we_n rising while ce_n is low
module flc_flash_model #(
   parameter logic [7:0] OP_SETUP = 8'h3C, // arbitrary opcode values
   parameter logic [7:0] OP_CONF  = 8'hC3,
   parameter logic [7:0] OP_CLRST = 8'h5A,
   parameter int         BUSY_CYC = 40
) (
   input  wire logic       ref_clk,
   input  wire logic       flash_ce_n,
   input  wire logic       flash_oe_n,
   input  wire logic       flash_we_n,
   input  wire logic [7:0] flash_dq_o,
   input  wire logic       powerdown_protect_pin_n,
   input  wire logic       override_high_voltage,
   input  wire logic       master,
   input  wire logic       vpp_low,
   input  wire logic       load,
   input  wire logic [7:0] lock_init,
   output logic [7:0]      dq_m,
   output logic            ready_busy_pin,
   output logic [7:0]      locks
);
   logic [7:0] dev_stat_reg = 8'h80;
   logic [7:0] last_q = 8'h00;
   logic       armed_reg = 1'b0;
   logic       we_q = 1'b1;
   int         busy_cnt = 0;
   wire        rd_en = !flash_ce_n && !flash_oe_n;

   // command decode, busy timer; master bit has no clear path
   always @(posedge ref_clk) begin
      we_q <= flash_we_n;
      if (load)
         locks <= lock_init;
      if (!powerdown_protect_pin_n) begin  // abort leaves locks unknown
         if (busy_cnt > 0)
            locks <= 8'hA5;
         busy_cnt <= 0;
         armed_reg <= 1'b0;
         dev_stat_reg <= 8'h80;
      end else if (busy_cnt > 1) begin
         busy_cnt <= busy_cnt - 1;
      end else if (busy_cnt == 1) begin
         busy_cnt <= 0;
         locks <= 8'h00;
         dev_stat_reg[7] <= 1'b1;
      end else if (flash_we_n && !we_q && !flash_ce_n) begin
         armed_reg <= (flash_dq_o == OP_SETUP);
         if (flash_dq_o == OP_CLRST)
            dev_stat_reg <= 8'h80;
         else if (armed_reg && flash_dq_o != OP_CONF)
            dev_stat_reg <= dev_stat_reg | 8'h30;
         else if (armed_reg && vpp_low)
            dev_stat_reg <= dev_stat_reg | 8'h28;
         else if (armed_reg && master && !override_high_voltage)
            dev_stat_reg <= dev_stat_reg | 8'h22;
         else if (armed_reg) begin
            dev_stat_reg[7] <= 1'b0;
            busy_cnt <= BUSY_CYC;
         end
      end
   end

   // every read gives status; a released bus shows the inverse
   always @(posedge ref_clk)
      if (rd_en)
         last_q <= dev_stat_reg;
   assign dq_m = rd_en ? dev_stat_reg : ~last_q;
   assign ready_busy_pin = (busy_cnt == 0);
endmodule

// *** tb/flc_ctrl_chk.sv ***
// checker for the flash lock controller: apb answer and pin timing
// assumes binding into flc_ctrl at its default pin timing
module flc_ctrl_chk
   import flc_pkg::*;
#(
   parameter int ADDR_W = 20
) (
   input wire logic              ref_clk, rst,
   input wire logic [7:0]        paddr,
   input wire logic              psel, penable, pwrite,
   input wire logic [31:0]       pwdata, prdata,
   input wire logic              pready, pslverr, irq,
   input wire logic [ADDR_W-1:0] flash_addr,
   input wire logic              flash_ce_n, flash_oe_n, flash_we_n,
   input wire logic [7:0]        flash_dq_o, flash_dq_i,
   input wire logic              flash_dq_oe, powerdown_protect_pin_n,
   input wire logic              override_high_voltage, ready_busy_pin
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   // bus answer
   property p_ans; psel && penable |-> pready && pslverr == (paddr > 8'h18);
   endproperty
   a_ans: assert property (p_ans)
      else $error("apb answer wrong");
   // host drives dq only inside a write cycle
   property p_drv; flash_dq_oe |-> !flash_ce_n && flash_oe_n; endproperty
   a_drv: assert property (p_drv)
      else $error("dq driven outside a write");
   property p_wr; !flash_we_n |-> !flash_ce_n && flash_oe_n; endproperty
   a_wr: assert property (p_wr)
      else $error("write strobe outside select");
   property p_wlen; $fell(flash_we_n) |-> (!flash_we_n)[*8] ##1
      !flash_we_n ##1 !flash_we_n ##1 flash_we_n; endproperty
   a_wlen: assert property (p_wlen)
      else $error("write strobe not ten cycles");
   property p_end; $rose(flash_we_n) |=> $rose(flash_ce_n); endproperty
   a_end: assert property (p_end)
      else $error("select not released after write");
   // address and data hold through the cycle
   property p_hold; !flash_ce_n && $past(!flash_ce_n) |-> $stable(flash_addr)
      && (!flash_dq_oe || $stable(flash_dq_o)); endproperty
   a_hold: assert property (p_hold)
      else $error("address or data moved in cycle");
   property p_ovr; !flash_ce_n |-> $stable(override_high_voltage); endproperty
   a_ovr: assert property (p_ovr)
      else $error("override moved during a cycle");
   property p_rst; $fell(rst) |-> flash_ce_n && !flash_dq_oe && !irq &&
      powerdown_protect_pin_n && !override_high_voltage; endproperty
   a_rst: assert property (p_rst)
      else $error("pins not idle after reset");
endmodule

bind flc_ctrl flc_ctrl_chk #(.ADDR_W(ADDR_W)) flc_ctrl_chk_inst (.ref_clk,
   .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
   .pslverr, .irq, .flash_addr, .flash_ce_n, .flash_oe_n, .flash_we_n,
   .flash_dq_o, .flash_dq_i, .flash_dq_oe, .powerdown_protect_pin_n,
   .override_high_voltage, .ready_busy_pin);

// *** tb/tb.sv ***
// testbench: flash lock controller driving the flash model over apb
// assumes model and checker are compiled ahead of this file
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import flc_pkg::*;
   localparam logic [7:0] OP_S = 8'h3C; // arbitrary opcodes
   localparam logic [7:0] OP_C = 8'hC3;
   localparam logic [7:0] OP_X = 8'h5A;
   logic ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, master = 1'b0, vpp_low = 1'b0, load = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, lvl = 32'h0, prdata, rd_q;
   logic pready, pslverr, err_q, irq, ready_busy_pin, flash_ce_n;
   logic flash_oe_n, flash_we_n, flash_dq_oe, powerdown_protect_pin_n;
   logic override_high_voltage;
   logic [19:0] flash_addr;
   logic [7:0] flash_dq_o, flash_dq_i, dq_m, locks;
   int bad_count = 0, total_checks = 0;

   // clock, and the dq pad shared by host and model
   always #5 ref_clk = ~ref_clk;
   assign flash_dq_i = flash_dq_oe ? flash_dq_o : dq_m;

   flc_ctrl flc_ctrl_inst (.ref_clk, .rst, .paddr, .psel, .penable, .pwrite,
      .pwdata, .prdata, .pready, .pslverr, .irq, .flash_addr, .flash_ce_n,
      .flash_oe_n, .flash_we_n, .flash_dq_o, .flash_dq_oe, .flash_dq_i,
      .powerdown_protect_pin_n, .override_high_voltage, .ready_busy_pin);
   flc_flash_model #(.OP_SETUP(OP_S), .OP_CONF(OP_C), .OP_CLRST(OP_X))
      flc_flash_model_inst (.ref_clk, .flash_ce_n, .flash_oe_n, .flash_we_n,
      .flash_dq_o, .powerdown_protect_pin_n, .override_high_voltage, .master,
      .vpp_low, .load, .lock_init(8'hFF), .dq_m, .ready_busy_pin, .locks);

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, got);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one apb transfer: setup, then access until pready
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1) @(posedge ref_clk);
      rd_q = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wait_idle();
      int n;
      n = 0;
      rd_q = 32'h100;
      while (rd_q[8] !== 1'b0 && n < 300) begin
         apb(1'b0, OFS_STAT, 32'h0);
         n++;
      end
      chk("idle", 32'h0, {31'h0, rd_q[8]});
   endtask

   task automatic seq(input logic [7:0] conf, stat, input logic [5:0] ev);
      apb(1'b1, OFS_CMD, {16'h0, conf, OP_S});
      apb(1'b1, OFS_CTRL, lvl | 32'h4);
      wait_idle();
      chk("status", {24'h0, stat}, {24'h0, rd_q[7:0]});
      apb(1'b0, OFS_IRQ, 32'h0);
      chk("events", {26'h0, ev}, rd_q);
   endtask

   // clear-status write, then a plain read must give clean status
   task automatic clr_status();
      apb(1'b1, OFS_CMD, {24'h0, OP_X});
      apb(1'b1, OFS_CTRL, lvl | 32'h1);
      wait_idle();
      apb(1'b1, OFS_CTRL, lvl | 32'h2);
      wait_idle();
      apb(1'b0, OFS_RDATA, 32'h0);
      chk("read data", 32'h80, rd_q);
      apb(1'b1, OFS_IRQ, 32'h3F);
   endtask

   task automatic set_locks();
      load <= 1'b1;
      @(posedge ref_clk);
      load <= 1'b0;
   endtask

   task automatic sc_regs();
      apb(1'b0, OFS_CTRL, 32'h0);
      chk("ctrl", CTRL_RST, rd_q);
      apb(1'b0, OFS_MASK, 32'h0);
      chk("mask", {26'h0, MASK_RST}, rd_q);
      apb(1'b1, OFS_ADDR, 32'hFFF1_2345);
      apb(1'b0, OFS_ADDR, 32'h0);
      chk("addr", 32'h0001_2345, rd_q);
      apb(1'b1, 8'h1C, 32'hFFFF_FFFF);
      apb(1'b0, 8'h1C, 32'h0);
      chk("unmapped", 32'h0, rd_q);
      chk("slverr", 32'h1, {31'h0, err_q});
   endtask

   task automatic sc_open();
      set_locks();
      apb(1'b1, OFS_MASK, 32'h1);
      seq(OP_C, 8'h80, 6'h01);
      chk("locks", 32'h0, {24'h0, locks});
      chk("flash addr", 32'h12345, {12'h0, flash_addr});
      chk("irq", 32'h1, {31'h0, irq});
      apb(1'b1, OFS_IRQ, 32'h3F);
      repeat (2) @(posedge ref_clk);
      chk("irq", 32'h0, {31'h0, irq});
      apb(1'b1, OFS_MASK, 32'h0);
   endtask

   task automatic sc_master();
      master <= 1'b1;
      set_locks();
      seq(OP_C, 8'hA2, 6'h13);
      chk("locks", 32'hFF, {24'h0, locks});
      chk("irq", 32'h0, {31'h0, irq});
      clr_status();
      lvl = 32'h8;
      apb(1'b1, OFS_CTRL, lvl);
      repeat (2) @(posedge ref_clk);
      chk("override", 32'h1, {31'h0, override_high_voltage});
      seq(OP_C, 8'h80, 6'h01);
      chk("locks", 32'h0, {24'h0, locks});
      apb(1'b1, OFS_IRQ, 32'h3F);
      lvl = 32'h0;
      apb(1'b1, OFS_CTRL, lvl);
      master <= 1'b0;
   endtask

   task automatic sc_faults();
      vpp_low <= 1'b1;
      seq(OP_C, 8'hA8, 6'h0B);
      clr_status();
      vpp_low <= 1'b0;
      seq(8'h00, 8'hB0, 6'h07);
      clr_status();
   endtask

   task automatic sc_abort();
      set_locks();
      apb(1'b1, OFS_CMD, {16'h0, OP_C, OP_S});
      apb(1'b1, OFS_CTRL, 32'h4);
      while (ready_busy_pin !== 1'b0) @(posedge ref_clk);
      apb(1'b1, OFS_CTRL, 32'h10);
      repeat (2) @(posedge ref_clk);
      chk("pin_n", 32'h0, {31'h0, powerdown_protect_pin_n});
      apb(1'b1, OFS_CTRL, 32'h0);
      wait_idle();
      apb(1'b0, OFS_IRQ, 32'h0);
      chk("abort", 32'h1, {31'h0, rd_q[EV_ABORT]});
      apb(1'b1, OFS_IRQ, 32'h3F);
      seq(OP_C, 8'h80, 6'h01);
      chk("locks", 32'h0, {24'h0, locks});
   endtask

   // hang guard, far beyond the thousand or so cycles the run takes
   initial begin
      #400000;
      bad_count++;
      report_and_stop();
   end

   initial begin
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      sc_regs();
      sc_open();
      sc_master();
      sc_faults();
      sc_abort();
      report_and_stop();
   end
endmodule
